// ---- core/ctt_timer.sv ----
`include "ctt_regs.svh"

module ctt_timer
	import ctt_pkg::*;
(
	input  wire logic        MCLK_IN,
	input  wire logic        RST_N_IN,
	input  wire logic        WATCH_CLK_IN,
	input  wire logic        SUB_MODE_IN,
	input  wire logic        EVENT_IN,
	input  wire logic [7:0]  AXI_AWADDR_IN,
	input  wire logic        AXI_AWVALID_IN,
	output logic             AXI_AWREADY_OUT,
	input  wire logic [31:0] AXI_WDATA_IN,
	input  wire logic [3:0]  AXI_WSTRB_IN,
	input  wire logic        AXI_WVALID_IN,
	output logic             AXI_WREADY_OUT,
	output logic [1:0]       AXI_BRESP_OUT,
	output logic             AXI_BVALID_OUT,
	input  wire logic        AXI_BREADY_IN,
	input  wire logic [7:0]  AXI_ARADDR_IN,
	input  wire logic        AXI_ARVALID_IN,
	output logic             AXI_ARREADY_OUT,
	output logic [31:0]      AXI_RDATA_OUT,
	output logic [1:0]       AXI_RRESP_OUT,
	output logic             AXI_RVALID_OUT,
	input  wire logic        AXI_RREADY_IN,
	output logic             TOGGLE_UPPER_OUT,
	output logic             TOGGLE_LOWER_OUT,
	output logic             IRQ_UPPER_OUT,
	output logic             IRQ_LOWER_OUT
);

	// synchronisers and prescalers
	logic [2:0]  ev_sync_r;
	logic [2:0]  wk_sync_r;
	logic [1:0]  sub_sync_r;
	logic [4:0]  pre_r;
	logic [1:0]  wdiv_r;
	logic        sub;
	logic        ev_tick;
	logic        wk_rise;
	logic [3:0]  itk;

	// bus slave
	ctt_wst_t    wst_r;
	ctt_wst_t    wst_nxt;
	logic        aw_have_r;
	logic        w_have_r;
	logic        awready_r;
	logic        wready_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        arready_r;
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;
	logic [7:0]  waddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        aw_take;
	logic        w_take;
	logic        ar_take;
	logic        rvalid_nxt;
	logic        wr_do;
	logic [7:0]  waddr_a;
	logic [7:0]  raddr_a;
	logic        wr_hit;
	logic        rd_hit;
	logic [31:0] rd_mux;
	logic        ctrl_wr;
	logic        stat_wr;
	logic        stat_rd;
	logic [1:0]  cnt_wr;
	logic [1:0]  cmp_wr;
	ctt_ctrl_t   wctl;
	ctt_stat_t   wst_d;
	ctt_stat_t   stat_v;

	// software visible state
	ctt_ctrl_t   ctrl_r;
	logic [15:0] cmp_r;
	logic [1:0]  ien_r;
	logic        edge_r;
	logic [1:0]  mclr_r;
	logic [1:0]  wie_r;

	// per half (0 lower, 1 upper)
	logic        mode16;
	logic [1:0]  tick;
	logic [1:0]  own_w;
	logic [1:0]  w_src;
	logic [1:0]  inc;
	logic [1:0]  clr;
	logic [1:0]  ld;
	logic [1:0]  eq;
	logic [1:0]  mx;
	logic [1:0]  evm;
	logic [1:0]  evw;
	ctt_cnt8_t   cnt [2];
	logic [1:0]  hold_r [2];
	logic        hm_r [2];
	logic        hw_r [2];
	logic        flag_m_r [2];
	logic        flag_w_r [2];
	logic        arm_m_r [2];
	logic        arm_w_r [2];
	logic        tog_r [2];
	logic        irq_r [2];

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ev_sync_r  <= 3'h0;
			wk_sync_r  <= 3'h0;
			sub_sync_r <= 2'h0;
			pre_r      <= 5'h00;
			wdiv_r     <= 2'h0;
		end else begin
			ev_sync_r  <= {ev_sync_r[1:0], EVENT_IN};
			wk_sync_r  <= {wk_sync_r[1:0], WATCH_CLK_IN};
			sub_sync_r <= {sub_sync_r[0], SUB_MODE_IN};
			pre_r      <= pre_r + 5'h01;
			wdiv_r     <= wk_rise ? wdiv_r + 2'h1 : wdiv_r;
		end
	end

	assign sub     = sub_sync_r[1];
	assign wk_rise = wk_sync_r[1] & ~wk_sync_r[2];
	// edge select 1 counts rising edges, 0 falling ones
	assign ev_tick = edge_r ? (ev_sync_r[1] & ~ev_sync_r[2]) :
		(~ev_sync_r[1] & ev_sync_r[2]);

	// low-power states stop every system-clock source
	assign itk[`CTT_SEL_D32] = ~sub & (pre_r == `CTT_D32_END);
	assign itk[`CTT_SEL_D16] = ~sub & (pre_r[3:0] == `CTT_D16_END);
	assign itk[`CTT_SEL_D4]  = ~sub & (pre_r[1:0] == `CTT_D4_END);
	assign itk[`CTT_SEL_W4]  = wk_rise & (wdiv_r == `CTT_W4_END);

	assign mode16 = ~ctrl_r.sel_u[2];

	// ---- bus slave ----
	assign aw_take = AXI_AWVALID_IN & awready_r;
	assign w_take  = AXI_WVALID_IN & wready_r;
	assign ar_take = AXI_ARVALID_IN & arready_r;
	assign wr_do   = (wst_r == CTT_W_IDLE) & aw_have_r & w_have_r;
	assign wst_nxt = wr_do ? CTT_W_RESP :
		(wst_r == CTT_W_RESP && AXI_BREADY_IN) ? CTT_W_IDLE : wst_r;
	assign rvalid_nxt = ar_take | (rvalid_r & ~AXI_RREADY_IN);

	assign waddr_a = {waddr_r[7:2], 2'h0};
	assign raddr_a = {AXI_ARADDR_IN[7:2], 2'h0};
	assign wctl    = ctt_ctrl_t'(wdata_r[7:0]);
	assign wst_d   = ctt_stat_t'(wdata_r[7:0]);
	assign ctrl_wr = wr_do & (waddr_a == `CTT_OFF_CTRL) & wstrb_r[0];
	assign stat_wr = wr_do & (waddr_a == `CTT_OFF_STAT) & wstrb_r[0];
	assign stat_rd = ar_take & (raddr_a == `CTT_OFF_STAT);
	assign cnt_wr  = {2{wr_do & (waddr_a == `CTT_OFF_CNT)}} & wstrb_r[1:0];
	assign cmp_wr  = {2{wr_do & (waddr_a == `CTT_OFF_CMP)}} & wstrb_r[1:0];
	assign wr_hit  = (waddr_a == `CTT_OFF_CTRL) | (waddr_a == `CTT_OFF_STAT) |
		(waddr_a == `CTT_OFF_CNT) | (waddr_a == `CTT_OFF_CMP) |
		(waddr_a == `CTT_OFF_IEN) | (waddr_a == `CTT_OFF_EDGE);

	assign stat_v = '{wrap_u: flag_w_r[1], match_u: flag_m_r[1],
		wie_u: wie_r[1], mclr_u: mclr_r[1], wrap_l: flag_w_r[0],
		match_l: flag_m_r[0], wie_l: wie_r[0], mclr_l: mclr_r[0]};

	// a watch-source count read may be one count off the true value
	assign rd_hit = (raddr_a == `CTT_OFF_CTRL) | (raddr_a == `CTT_OFF_STAT) |
		(raddr_a == `CTT_OFF_CNT) | (raddr_a == `CTT_OFF_CMP) |
		(raddr_a == `CTT_OFF_IEN) | (raddr_a == `CTT_OFF_EDGE);
	assign rd_mux =
		(raddr_a == `CTT_OFF_CTRL) ? {24'h0, ctrl_r} :
		(raddr_a == `CTT_OFF_STAT) ? {24'h0, stat_v} :
		(raddr_a == `CTT_OFF_CNT)  ? {16'h0, cnt[1], cnt[0]} :
		(raddr_a == `CTT_OFF_CMP)  ? {16'h0, cmp_r} :
		(raddr_a == `CTT_OFF_IEN)  ? {30'h0, ien_r} :
		(raddr_a == `CTT_OFF_EDGE) ? {31'h0, edge_r} : 32'h0;

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			wst_r     <= CTT_W_IDLE;
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `CTT_RESP_OK;
			waddr_r   <= 8'h00;
			wdata_r   <= 32'h0;
			wstrb_r   <= 4'h0;
		end else begin
			wst_r     <= wst_nxt;
			aw_have_r <= (aw_have_r | aw_take) & ~wr_do;
			w_have_r  <= (w_have_r | w_take) & ~wr_do;
			awready_r <= (wst_nxt == CTT_W_IDLE) & ~(aw_have_r | aw_take);
			wready_r  <= (wst_nxt == CTT_W_IDLE) & ~(w_have_r | w_take);
			bvalid_r  <= wst_nxt == CTT_W_RESP;
			bresp_r   <= wr_do ? (wr_hit ? `CTT_RESP_OK : `CTT_RESP_ERR) :
				bresp_r;
			waddr_r   <= aw_take ? AXI_AWADDR_IN : waddr_r;
			wdata_r   <= w_take ? AXI_WDATA_IN : wdata_r;
			wstrb_r   <= w_take ? AXI_WSTRB_IN : wstrb_r;
		end
	end

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0;
			rresp_r   <= `CTT_RESP_OK;
		end else begin
			arready_r <= ~rvalid_nxt;
			rvalid_r  <= rvalid_nxt;
			rdata_r   <= ar_take ? rd_mux : rdata_r;
			rresp_r   <= ar_take ? (rd_hit ? `CTT_RESP_OK : `CTT_RESP_ERR) :
				rresp_r;
		end
	end

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ctrl_r <= ctt_ctrl_t'(`CTT_REG8_RST);
			cmp_r  <= `CTT_CMP_RST;
			ien_r  <= 2'h0;
			edge_r <= 1'b0;
			mclr_r <= 2'h0;
			wie_r  <= 2'h0;
		end else begin
			ctrl_r <= ctrl_wr ? wctl : ctrl_r;
			cmp_r[7:0]  <= cmp_wr[0] ? wdata_r[7:0] : cmp_r[7:0];
			cmp_r[15:8] <= cmp_wr[1] ? wdata_r[15:8] : cmp_r[15:8];
			if (wr_do && waddr_a == `CTT_OFF_IEN && wstrb_r[0]) begin
				ien_r <= wdata_r[1:0];
			end
			if (wr_do && waddr_a == `CTT_OFF_EDGE && wstrb_r[0]) begin
				edge_r <= wdata_r[0];
			end
			if (stat_wr) begin
				mclr_r <= {wst_d.mclr_u, wst_d.mclr_l};
				wie_r  <= {wst_d.wie_u, wst_d.wie_l};
			end
		end
	end

	// ---- counting and events ----
	// in 16-bit mode the upper half follows the lower source
	assign w_src[0] = own_w[0];
	assign w_src[1] = mode16 ? own_w[0] : own_w[1];
	assign inc[0]   = tick[0];
	assign inc[1]   = mode16 ? tick[0] & mx[0] : tick[1];

	// a match is signalled on the tick that leaves the matching value
	assign evm[0] = tick[0] & eq[0] & ~cmp_wr[0];
	assign evm[1] = mode16 ?
		tick[0] & eq[0] & eq[1] & ~(|cmp_wr) :
		tick[1] & eq[1] & ~cmp_wr[1];
	assign evw[0] = tick[0] & mx[0] & ~ld[0];
	assign evw[1] = mode16 ?
		tick[0] & mx[0] & mx[1] & ~(|ld) :
		tick[1] & mx[1] & ~ld[1];
	assign clr[0] = mode16 ? evm[1] & mclr_r[1] : evm[0] & mclr_r[0];
	assign clr[1] = evm[1] & mclr_r[1];

	for (genvar h = 0; h < 2; h++) begin : g_half
		wire logic [2:0] sel = (h == 1) ? ctrl_r.sel_u : ctrl_r.sel_l;
		wire logic lvl_new   = (h == 1) ? wctl.lvl_u : wctl.lvl_l;
		wire logic wd_m      = (h == 1) ? wst_d.match_u : wst_d.match_l;
		wire logic wd_w      = (h == 1) ? wst_d.wrap_u : wst_d.wrap_l;
		wire logic evx       = (evm[h] | evw[h]) & w_src[h];
		wire logic hon       = hold_r[h] != 2'h0;
		wire logic set_m     = evm[h] | (hon & hm_r[h]);
		wire logic set_w     = evw[h] | (hon & hw_r[h]);
		wire logic first_w   = hold_r[h] == `CTT_HOLD_W;
		wire logic iwin_m    = evm[h] | (first_w & hm_r[h]);
		wire logic iwin_w    = evw[h] | (first_w & hw_r[h]);
		wire logic clr_m     = stat_wr & ~wd_m & arm_m_r[h];
		wire logic clr_w     = stat_wr & ~wd_w & arm_w_r[h];
		wire logic fm_nxt    = set_m | (flag_m_r[h] & ~clr_m);
		wire logic fw_nxt    = set_w | (flag_w_r[h] & ~clr_w);

		// only the lower half can take the event pin
		assign tick[h]  = sel[2] ? itk[sel[1:0]] : (h == 0) & ev_tick;
		assign own_w[h] = sel[2] & (sel[1:0] == `CTT_SEL_W4) & ~sub;
		// watch-source writes in active mode would race the sync stage
		assign ld[h]    = cnt_wr[h] & ~w_src[h];

		ctt_half u_half (
			.clk_in     (MCLK_IN),
			.rst_n_in   (RST_N_IN),
			.inc_in     (inc[h]),
			.clr_in     (clr[h]),
			.ld_in      (ld[h]),
			.ld_data_in (wdata_r[h*8 +: 8]),
			.cmp_in     (cmp_r[h*8 +: 8]),
			.cnt_out    (cnt[h]),
			.max_out    (mx[h]),
			.eq_out     (eq[h])
		);

		always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
			if (!RST_N_IN) begin
				hold_r[h]   <= 2'h0;
				hm_r[h]     <= 1'b0;
				hw_r[h]     <= 1'b0;
				flag_m_r[h] <= 1'b0;
				flag_w_r[h] <= 1'b0;
				arm_m_r[h]  <= 1'b0;
				arm_w_r[h]  <= 1'b0;
				tog_r[h]    <= 1'b0;
				irq_r[h]    <= 1'b0;
			end else begin
				hold_r[h]   <= evx ? `CTT_HOLD_W :
					(hon && wk_rise) ? hold_r[h] - 2'h1 : hold_r[h];
				hm_r[h]     <= evx ? evm[h] : hm_r[h];
				hw_r[h]     <= evx ? evw[h] : hw_r[h];
				flag_m_r[h] <= fm_nxt;
				flag_w_r[h] <= fw_nxt;
				arm_m_r[h]  <= stat_rd ? flag_m_r[h] : arm_m_r[h] & fm_nxt;
				arm_w_r[h]  <= stat_rd ? flag_w_r[h] : arm_w_r[h] & fw_nxt;
				tog_r[h]    <= ctrl_wr ? lvl_new :
					(evm[h] && ien_r[h]) ? ~tog_r[h] : tog_r[h];
				irq_r[h]    <= ien_r[h] & (iwin_m | (iwin_w & wie_r[h]));
			end
		end
	end

	assign AXI_AWREADY_OUT  = awready_r;
	assign AXI_WREADY_OUT   = wready_r;
	assign AXI_BVALID_OUT   = bvalid_r;
	assign AXI_BRESP_OUT    = bresp_r;
	assign AXI_ARREADY_OUT  = arready_r;
	assign AXI_RVALID_OUT   = rvalid_r;
	assign AXI_RDATA_OUT    = rdata_r;
	assign AXI_RRESP_OUT    = rresp_r;
	// the lower pin is not meaningful in 16-bit mode; use it as a port
	assign TOGGLE_UPPER_OUT = tog_r[1];
	assign TOGGLE_LOWER_OUT = tog_r[0];
	assign IRQ_UPPER_OUT    = irq_r[1];
	assign IRQ_LOWER_OUT    = irq_r[0];

	a_match_sets_flag: assert property (
		@(posedge MCLK_IN) disable iff (!RST_N_IN)
		evm[1] |=> flag_m_r[1] ##1 (flag_m_r[1] || $past(stat_wr)))
		else $error("upper match flag not set");

	a_lower_wrap_flag: assert property (
		@(posedge MCLK_IN) disable iff (!RST_N_IN)
		mode16 && tick[0] && mx[0] && !ld[0] |=> flag_w_r[0])
		else $error("lower wrap flag missed in 16-bit mode");

	a_clear_whole16: assert property (
		@(posedge MCLK_IN) disable iff (!RST_N_IN)
		mode16 && evm[1] && mclr_r[1] && ld == 2'h0
		|=> cnt[0] == 8'h00 && cnt[1] == 8'h00)
		else $error("16-bit clear on match failed");

	a_match_toggles: assert property (
		@(posedge MCLK_IN) disable iff (!RST_N_IN)
		!ctrl_wr && evm[0] && ien_r[0] |=> tog_r[0] != $past(tog_r[0]))
		else $error("toggle pin did not invert");

	a_write_level_wins: assert property (
		@(posedge MCLK_IN) disable iff (!RST_N_IN)
		ctrl_wr |=> TOGGLE_UPPER_OUT == ctrl_r.lvl_u
			&& TOGGLE_LOWER_OUT == ctrl_r.lvl_l)
		else $error("written level not driven");

	a_cmp_write_cancel: assert property (
		@(posedge MCLK_IN) disable iff (!RST_N_IN)
		!mode16 && cmp_wr[0] && tick[0] && eq[0] && !flag_m_r[0]
			&& hold_r[0] == 2'h0 |=> !flag_m_r[0])
		else $error("match not cancelled by compare write");

	a_sub_mode_stops: assert property (
		@(posedge MCLK_IN) disable iff (!RST_N_IN)
		sub && ctrl_r.sel_l[2] && ctrl_r.sel_l[1:0] != `CTT_SEL_W4
			&& !cnt_wr[0] && !clr[0] |=> $stable(cnt[0]))
		else $error("counter ran on a stopped source");

	a_stretch_resets: assert property (
		@(posedge MCLK_IN) disable iff (!RST_N_IN)
		hold_r[1] != 2'h0 && hm_r[1] |=> flag_m_r[1])
		else $error("flag cleared during stretch");

	a_watch_blocks_wr: assert property (
		@(posedge MCLK_IN) disable iff (!RST_N_IN)
		cnt_wr[0] && w_src[0] && !inc[0] && !clr[0] |=> $stable(cnt[0]))
		else $error("counter write took effect on watch source");

endmodule // ctt_timer

// ---- inc/ctt_regs.svh ----
`ifndef CTT_REGS_SVH
`define CTT_REGS_SVH

// register byte offsets on the bus
`define CTT_OFF_CTRL   8'h00
`define CTT_OFF_STAT   8'h04
`define CTT_OFF_CNT    8'h08
`define CTT_OFF_CMP    8'h0c
`define CTT_OFF_IEN    8'h10
`define CTT_OFF_EDGE   8'h14

// reset values and counter maximum
`define CTT_CNT8_RST   8'h00
`define CTT_CMP_RST    16'hffff
`define CTT_REG8_RST   8'h00
`define CTT_CNT8_MAX   8'hff

// clock select codes (low two bits, msb set)
`define CTT_SEL_D32    2'h0
`define CTT_SEL_D16    2'h1
`define CTT_SEL_D4     2'h2
`define CTT_SEL_W4     2'h3

// prescaler end counts
`define CTT_D32_END    5'h1f
`define CTT_D16_END    4'hf
`define CTT_D4_END     2'h3
`define CTT_W4_END     2'h3

// event stretch in watch-clock cycles under the watch source
`define CTT_HOLD_W     2'h2

// bus responses
`define CTT_RESP_OK    2'h0
`define CTT_RESP_ERR   2'h2

`endif

// ---- inc/ctt_pkg.sv ----
package ctt_pkg;

	typedef logic [7:0] ctt_cnt8_t;

	typedef struct packed {
		logic       lvl_u;
		logic [2:0] sel_u;
		logic       lvl_l;
		logic [2:0] sel_l;
	} ctt_ctrl_t;

	typedef struct packed {
		logic wrap_u;
		logic match_u;
		logic wie_u;
		logic mclr_u;
		logic wrap_l;
		logic match_l;
		logic wie_l;
		logic mclr_l;
	} ctt_stat_t;

	typedef enum logic [1:0] {
		CTT_W_IDLE = 2'b01,
		CTT_W_RESP = 2'b10
	} ctt_wst_t;

endpackage

// ---- core/ctt_half.sv ----
`include "ctt_regs.svh"

module ctt_half
	import ctt_pkg::*;
(
	input  wire logic      clk_in,
	input  wire logic      rst_n_in,
	input  wire logic      inc_in,
	input  wire logic      clr_in,
	input  wire logic      ld_in,
	input  wire ctt_cnt8_t ld_data_in,
	input  wire ctt_cnt8_t cmp_in,
	output ctt_cnt8_t      cnt_out,
	output logic           max_out,
	output logic           eq_out
);

	ctt_cnt8_t cnt_r;
	ctt_cnt8_t cnt_nxt;

	// a software load beats a clear, a clear beats an increment
	assign cnt_nxt = ld_in ? ld_data_in :
		clr_in ? `CTT_CNT8_RST :
		inc_in ? cnt_r + 8'h01 : cnt_r;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_r <= `CTT_CNT8_RST;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign cnt_out = cnt_r;
	assign max_out = cnt_r == `CTT_CNT8_MAX;
	assign eq_out  = cnt_r == cmp_in;

	a_load_wins: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		ld_in |=> cnt_r == $past(ld_data_in))
		else $error("counter load lost");

	a_wrap_to_zero: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		inc_in && max_out && !ld_in && !clr_in |=> cnt_r == 8'h00)
		else $error("counter did not wrap to zero");

endmodule // ctt_half

// ---- sim/ctt_event_src.sv ----
module ctt_event_src #(
	parameter int HOLD = 4
) (
	input  wire logic       clk_in,
	input  wire logic       start_in,
	input  wire logic [7:0] pulses_in,
	output logic            busy_out,
	output logic            event_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		busy_out = 1'b0;
		event_out = 1'b0;
	end

	// each level is held HOLD clocks: a level of one clock or more is caught
	always @(posedge clk_in) begin
		if (start_in) begin
			busy_out <= 1'b1;
			for (int i = 0; i < pulses_in; i++) begin
				event_out <= 1'b1;
				repeat (HOLD) @(posedge clk_in);
				event_out <= 1'b0;
				repeat (HOLD) @(posedge clk_in);
			end
			busy_out <= 1'b0;
		end
	end
endmodule // ctt_event_src

// ---- sim/ctt_timer_test.sv ----
`include "ctt_regs.svh"

module ctt_timer_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic        MCLK_IN = 0, RST_N_IN = 0, WATCH_CLK_IN = 0;
	logic        SUB_MODE_IN = 0, EVENT_IN;
	logic [7:0]  AXI_AWADDR_IN = 0, AXI_ARADDR_IN = 0;
	logic        AXI_AWVALID_IN = 0, AXI_WVALID_IN = 0, AXI_BREADY_IN = 0;
	logic        AXI_ARVALID_IN = 0, AXI_RREADY_IN = 0;
	logic [31:0] AXI_WDATA_IN = 0;
	logic [3:0]  AXI_WSTRB_IN = 0;
	logic        AXI_AWREADY_OUT, AXI_WREADY_OUT, AXI_BVALID_OUT;
	logic        AXI_ARREADY_OUT, AXI_RVALID_OUT;
	logic [1:0]  AXI_BRESP_OUT, AXI_RRESP_OUT, r;
	logic [31:0] AXI_RDATA_OUT, v;
	logic        TOGGLE_UPPER_OUT, TOGGLE_LOWER_OUT;
	logic        IRQ_UPPER_OUT, IRQ_LOWER_OUT, seen;
	logic        ev_start = 0, ev_busy;
	logic [7:0]  ev_num = 0;
	int          errors = 0, checks_done = 0, n;
	int          divs[3] = '{32, 16, 4};

	always #2 MCLK_IN = ~MCLK_IN;
	// watch clock runs unrelated in phase and rate to the system clock
	always #17 WATCH_CLK_IN = ~WATCH_CLK_IN;

	ctt_timer dut (.MCLK_IN, .RST_N_IN, .WATCH_CLK_IN, .SUB_MODE_IN,
		.EVENT_IN, .AXI_AWADDR_IN, .AXI_AWVALID_IN, .AXI_AWREADY_OUT,
		.AXI_WDATA_IN, .AXI_WSTRB_IN, .AXI_WVALID_IN, .AXI_WREADY_OUT,
		.AXI_BRESP_OUT, .AXI_BVALID_OUT, .AXI_BREADY_IN, .AXI_ARADDR_IN,
		.AXI_ARVALID_IN, .AXI_ARREADY_OUT, .AXI_RDATA_OUT, .AXI_RRESP_OUT,
		.AXI_RVALID_OUT, .AXI_RREADY_IN, .TOGGLE_UPPER_OUT,
		.TOGGLE_LOWER_OUT, .IRQ_UPPER_OUT, .IRQ_LOWER_OUT);

	ctt_event_src src (.clk_in(MCLK_IN), .start_in(ev_start),
		.pulses_in(ev_num), .busy_out(ev_busy), .event_out(EVENT_IN));

	task automatic close_out();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask

	task automatic tmo(input int k);
		if (k >= 300) begin
			errors++;
			$display("MISMATCH timeout exp 0 seen %0d", k);
			close_out();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] rs);
		int k;
		logic aw;
		logic w;
		@(posedge MCLK_IN);
		k = 0;
		aw = 1;
		w = 1;
		AXI_AWADDR_IN <= a;
		AXI_WDATA_IN <= d;
		AXI_WSTRB_IN <= 4'hf;
		AXI_AWVALID_IN <= 1'b1;
		AXI_WVALID_IN <= 1'b1;
		AXI_BREADY_IN <= 1'b1;
		do begin
			@(posedge MCLK_IN);
			k++;
			if (aw && AXI_AWREADY_OUT === 1'b1) begin
				aw = 0;
				AXI_AWVALID_IN <= 1'b0;
			end
			if (w && AXI_WREADY_OUT === 1'b1) begin
				w = 0;
				AXI_WVALID_IN <= 1'b0;
			end
		end while (AXI_BVALID_OUT !== 1'b1 && k < 300);
		rs = AXI_BRESP_OUT;
		AXI_BREADY_IN <= 1'b0;
		tmo(k);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] rs);
		int k;
		logic ar;
		@(posedge MCLK_IN);
		k = 0;
		ar = 1;
		AXI_ARADDR_IN <= a;
		AXI_ARVALID_IN <= 1'b1;
		AXI_RREADY_IN <= 1'b1;
		do begin
			@(posedge MCLK_IN);
			k++;
			if (ar && AXI_ARREADY_OUT === 1'b1) begin
				ar = 0;
				AXI_ARVALID_IN <= 1'b0;
			end
		end while (AXI_RVALID_OUT !== 1'b1 && k < 300);
		d = AXI_RDATA_OUT;
		rs = AXI_RRESP_OUT;
		AXI_RREADY_IN <= 1'b0;
		tmo(k);
	endtask

	task automatic put(input logic [7:0] a, input logic [31:0] d);
		wr(a, d, r);
		chk("bresp", 32'h0, r);
	endtask

	task automatic get(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		rd(a, v, r);
		chk("rresp", 32'h0, r);
		chk(nm, e, v);
	endtask

	// the request is a one-cycle pulse except under the watch source, so every edge is looked at
	task automatic wait_irq(input int lim, input logic lo,
		output logic hit);
		hit = 0;
		for (int i = 0; i < lim && !hit; i++) begin
			@(posedge MCLK_IN);
			hit = ((lo ? IRQ_LOWER_OUT : IRQ_UPPER_OUT) === 1'b1);
		end
	endtask

	initial begin
		repeat (16) @(posedge MCLK_IN);
		RST_N_IN <= 1'b1;
		repeat (2) @(posedge MCLK_IN);
		get(`CTT_OFF_CTRL, 32'h0, "ctrl");
		get(`CTT_OFF_STAT, 32'h0, "stat");
		get(`CTT_OFF_CNT, 32'h0, "count");
		get(`CTT_OFF_CMP, 32'h0000ffff, "compare");
		get(`CTT_OFF_IEN, 32'h0, "irq_en");
		get(`CTT_OFF_EDGE, 32'h0, "edge");
		rd(8'h18, v, r);
		chk("rresp_unmapped", 32'h2, r);
		wr(8'h18, 32'h1, r);
		chk("bresp_unmapped", 32'h2, r);
		for (int e = 1; e >= 0; e--) begin
			put(`CTT_OFF_EDGE, e);
			ev_num <= 8'h03;
			ev_start <= 1'b1;
			@(posedge MCLK_IN);
			ev_start <= 1'b0;
			repeat (2) @(posedge MCLK_IN);
			n = 0;
			while (ev_busy !== 1'b0 && n < 300) begin
				@(posedge MCLK_IN);
				n++;
			end
			tmo(n);
			repeat (8) @(posedge MCLK_IN);
			get(`CTT_OFF_CNT, 3 * (2 - e), "count_event");
		end
		for (int s = 0; s < 3; s++) begin
			put(`CTT_OFF_CNT, 32'h0);
			put(`CTT_OFF_CTRL, 32'h4 | s);
			repeat (64) @(posedge MCLK_IN);
			put(`CTT_OFF_CTRL, 32'h0);
			rd(`CTT_OFF_CNT, v, r);
			n = 68 / divs[s];
			chk("count_rate", 1, v + 1 >= n && v <= n + 1);
		end
		put(`CTT_OFF_CMP, 32'h10);
		put(`CTT_OFF_STAT, 32'h10);
		put(`CTT_OFF_IEN, 32'h2);
		put(`CTT_OFF_CNT, 32'h0);
		put(`CTT_OFF_CTRL, 32'h06);
		wait_irq(400, 1'b0, seen);
		chk("irq_match", 1, seen);
		chk("toggle_u", 1, TOGGLE_UPPER_OUT);
		rd(`CTT_OFF_CNT, v, r);
		chk("count_cleared", 1, v < 3);
		put(`CTT_OFF_CTRL, 32'h0);
		put(`CTT_OFF_STAT, 32'h10);
		get(`CTT_OFF_STAT, 32'h54, "stat_kept");
		put(`CTT_OFF_STAT, 32'h10);
		get(`CTT_OFF_STAT, 32'h10, "stat_cleared");
		put(`CTT_OFF_CMP, 32'h8080);
		for (int ie = 0; ie < 2; ie++) begin
			put(`CTT_OFF_STAT, ie << 5);
			put(`CTT_OFF_CNT, 32'hfe00);
			put(`CTT_OFF_CTRL, 32'h64);
			wait_irq(24, 1'b0, seen);
			chk("irq_wrap", ie, seen);
			put(`CTT_OFF_CTRL, 32'h0);
			get(`CTT_OFF_STAT, 32'h80 | (ie << 5), "stat_wrap");
			rd(`CTT_OFF_CNT, v, r);
			chk("count_split", 1, v[15:8] < 8'h10 && v[7:0] < 8'h03);
			put(`CTT_OFF_STAT, ie << 5);
		end
		// 8-bit lower half: level load, then match interrupt and toggle
		put(`CTT_OFF_CMP, 32'h8003);
		put(`CTT_OFF_IEN, 32'h1);
		put(`CTT_OFF_CNT, 32'h0);
		put(`CTT_OFF_CTRL, 32'hce);
		chk("toggle_u_lvl", 1, TOGGLE_UPPER_OUT);
		chk("toggle_l_lvl", 1, TOGGLE_LOWER_OUT);
		wait_irq(60, 1'b1, seen);
		chk("irq_lower", 1, seen);
		chk("toggle_l", 0, TOGGLE_LOWER_OUT);
		chk("irq_upper_quiet", 0, IRQ_UPPER_OUT);
		put(`CTT_OFF_CTRL, 32'h08);
		chk("toggle_l_reload", 1, TOGGLE_LOWER_OUT);
		put(`CTT_OFF_CNT, 32'h0);
		SUB_MODE_IN <= 1'b1;
		put(`CTT_OFF_CTRL, 32'h06);
		repeat (100) @(posedge MCLK_IN);
		get(`CTT_OFF_CNT, 32'h0, "count_halted");
		put(`CTT_OFF_CTRL, 32'h07);
		repeat (400) @(posedge MCLK_IN);
		rd(`CTT_OFF_CNT, v, r);
		chk("count_watch", 1, v > 0 && v < 32'h20);
		put(`CTT_OFF_CNT, 32'h0100);
		rd(`CTT_OFF_CNT, v, r);
		chk("count_sub_write", 32'h01, v[15:8]);
		SUB_MODE_IN <= 1'b0;
		repeat (8) @(posedge MCLK_IN);
		put(`CTT_OFF_CNT, 32'h1234);
		rd(`CTT_OFF_CNT, v, r);
		chk("count_write_ignored", 1, v[15:8] !== 8'h12);
		put(`CTT_OFF_CTRL, 32'h0);
		close_out();
	end
endmodule // ctt_timer_test
